// ---- src/iad_pkg.sv ----
package iad_pkg;

	// Clock and internal sample timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned INT_SAMPLE_SPS = 4250;
	localparam int unsigned INT_SAMPLE_CYCLES = CLK_HZ / INT_SAMPLE_SPS;
	localparam logic [11:0] INT_TICK_LAST = 12'(INT_SAMPLE_CYCLES - 1);

	// Decimation setting that gives a 1 Hz update at the nominal rate
	localparam logic [15:0] DEC_SETTING_1HZ = 16'h1099;

	// Angle step scale in Q32: 2^46 / (144000 * fs)
	// Rate LSB 0.005/2^16 dps, angle LSB 720/2^31 deg, trapezoid 1/(2 fs)
	localparam logic [63:0] SCALE_NUM = 64'h0000_4000_0000_0000;
	localparam logic [63:0] SCALE_DEN_UNIT = 64'h0000_0000_0002_3280;
	localparam logic [31:0] INT_SCALE_Q32 =
		32'(SCALE_NUM / (SCALE_DEN_UNIT * 64'(INT_SAMPLE_SPS)));

	// Accumulator width: holds 4250 * 2 * full-scale rate with margin
	localparam int unsigned ACC_W = 48;
	localparam int unsigned SCL_W = 33;
	localparam int unsigned PROD_W = ACC_W + SCL_W;
	localparam int unsigned PROD_LSB = 32;

	// Register byte addresses (word pairs, even address selects)
	localparam logic [6:0] ADDR_PAGE_SELECT = 7'h00;
	localparam logic [6:0] ADDR_Z_RATE_LOW = 7'h18;
	localparam logic [6:0] ADDR_Z_RATE_HIGH = 7'h1a;
	localparam logic [6:0] ADDR_X_ANGLE_LOW = 7'h40;
	localparam logic [6:0] ADDR_X_ANGLE_HIGH = 7'h42;
	localparam logic [6:0] ADDR_Y_ANGLE_LOW = 7'h44;
	localparam logic [6:0] ADDR_Y_ANGLE_HIGH = 7'h46;
	localparam logic [6:0] ADDR_Z_ANGLE_LOW = 7'h48;
	localparam logic [6:0] ADDR_Z_ANGLE_HIGH = 7'h4a;

	// Page holding the output registers, page select reset value
	localparam logic [15:0] PAGE_OUTPUTS = 16'h0000;
	localparam logic [15:0] PAGE_SELECT_RESET = 16'h0000;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	// Three-axis 32-bit twos complement values
	typedef struct packed {
		logic signed [31:0] x;
		logic signed [31:0] y;
		logic signed [31:0] z;
	} iad_axes_t;

	// One register access from the serial front end
	typedef struct packed {
		logic rd;
		logic wr;
		logic [6:0] addr;
		logic [15:0] wdata;
	} iad_reg_req_t;

	// Output update sequencer
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SCALE = 2'b01,
		ST_PUBLISH = 2'b10
	} iad_state_t;

endpackage

// ---- src/iad_angle_regs.sv ----
module iad_angle_regs (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ext_clk_sel,
	input wire logic i_ext_sample_clk,
	input wire logic [31:0] i_ext_scale_q32,
	input wire logic [15:0] i_decimation_setting,
	input wire iad_pkg::iad_axes_t i_rate,
	input wire iad_pkg::iad_axes_t i_accel,
	input wire iad_pkg::iad_reg_req_t i_reg_req,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic [15:0] o_register_page_select,
	output iad_pkg::iad_axes_t o_accel_words,
	output logic o_sample_tick,
	output logic o_data_update
);
	import iad_pkg::*;

	// Word of a 32-bit pair: high selects the upper half
	function automatic logic [15:0] pair_word(
		input logic [31:0] value,
		input logic high
	);
		pair_word = high ? value[31:16] : value[15:0];
	endfunction

	// Page select answers at 0x00/0x01 on every page
	function automatic logic is_page_addr(input logic [6:0] addr);
		is_page_addr = (addr[6:1] == ADDR_PAGE_SELECT[6:1]);
	endfunction

	// Sample timing state
	logic [11:0] int_cnt_reg;
	logic [11:0] int_cnt_next;
	logic ext_sync1_reg;
	logic ext_sync2_reg;
	logic ext_sync3_reg;
	logic int_tick;
	logic ext_tick;
	logic sample_tick;

	// Window state
	logic [15:0] win_cnt_reg;
	logic [15:0] win_cnt_next;
	logic win_end;
	iad_state_t state_reg;
	iad_state_t state_next;
	logic [31:0] scale_reg;
	logic [31:0] scale_sel;
	logic scaling;
	logic publishing;

	// Output registers: rate and accel as whole 32-bit pairs, plus page and read state
	logic [31:0] z_rate_reg;
	logic [31:0] z_rate_hold_reg;
	iad_axes_t accel_reg;
	logic [15:0] page_reg;
	logic [15:0] rdata_reg;
	logic rvalid_reg;
	logic update_reg;

	// Per-axis views
	logic signed [31:0] rate_arr [3];
	logic [31:0] angle_w [3];

	// Read decode
	logic on_outputs;
	logic [15:0] rd_word;
	logic rd_hit;
	logic page_hit;
	logic page_wr;
	logic [15:0] rd_sel;

	// Internal sample clock: one tick every INT_SAMPLE_CYCLES
	assign int_tick = (int_cnt_reg == INT_TICK_LAST);
	assign int_cnt_next = int_tick ? 12'h000 : int_cnt_reg + 12'h001;

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			int_cnt_reg <= 12'h000;
		end else begin
			int_cnt_reg <= int_cnt_next;
		end
	end

	// External sample clock pin: two-flop sync
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			ext_sync1_reg <= 1'b0;
			ext_sync2_reg <= 1'b0;
		end else begin
			ext_sync1_reg <= i_ext_sample_clk;
			ext_sync2_reg <= ext_sync1_reg;
		end
	end

	// Delayed copy for the edge detect; idles low like the pin
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			ext_sync3_reg <= 1'b0;
		end else begin
			ext_sync3_reg <= ext_sync2_reg;
		end
	end

	// Sample source select, internal or external rising edge
	assign ext_tick = ext_sync2_reg & ~ext_sync3_reg;
	assign sample_tick = i_ext_clk_sel ? ext_tick : int_tick;
	assign scale_sel = i_ext_clk_sel ? i_ext_scale_q32 : INT_SCALE_Q32;

	// Window counter: decimation setting plus one samples per window
	assign win_end = sample_tick && (win_cnt_reg >= i_decimation_setting);
	assign win_cnt_next = win_end ? 16'h0000 : win_cnt_reg + 16'h0001;

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			win_cnt_reg <= 16'h0000;
		end else if (sample_tick) begin
			win_cnt_reg <= win_cnt_next;
		end
	end

	// Axis order in the per-axis arrays: 0 = x, 1 = y, 2 = z
	assign rate_arr[0] = i_rate.x;
	assign rate_arr[1] = i_rate.y;
	assign rate_arr[2] = i_rate.z;

	// Trapezoid integrator, one per axis
	for (genvar a = 0; a < 3; a++) begin : g_axis
		logic signed [31:0] prev_reg;
		logic signed [ACC_W-1:0] acc_reg;
		logic signed [ACC_W-1:0] acc_hold_reg;
		logic signed [ACC_W-1:0] pair_sum;
		logic signed [ACC_W-1:0] acc_sum;
		logic signed [SCL_W-1:0] scale_s;
		logic signed [PROD_W-1:0] prod;
		logic [31:0] angle_reg;
		logic [31:0] angle_pub_reg;
		logic over_range;
		logic [31:0] angle_sat;

		// Rate sample plus the previous one, widened before adding
		assign pair_sum = ACC_W'(rate_arr[a]) + ACC_W'(prev_reg);
		assign acc_sum = acc_reg + pair_sum;
		// Scale by 1/(2 fs) into 720/2^31 degree counts
		assign scale_s = $signed({1'b0, scale_reg});
		assign prod = PROD_W'(acc_hold_reg) * PROD_W'(scale_s);
		// Saturate rather than wrap when a window over-ranges
		assign over_range = (prod[PROD_W-1:PROD_LSB+31] != '0) &&
			(prod[PROD_W-1:PROD_LSB+31] != '1);
		assign angle_sat = over_range ?
			(prod[PROD_W-1] ? 32'h8000_0000 : 32'h7fff_ffff) :
			prod[PROD_LSB+31:PROD_LSB];

		// Previous rate sample, kept for the trapezoid
		always_ff @(posedge i_sys_clk or posedge i_reset) begin
			if (i_reset) begin
				prev_reg <= 32'sh0000_0000;
			end else if (sample_tick) begin
				prev_reg <= rate_arr[a];
			end
		end

		// Accumulate each sample, restart at the window end
		always_ff @(posedge i_sys_clk or posedge i_reset) begin
			if (i_reset) begin
				acc_reg <= '0;
			end else if (sample_tick) begin
				acc_reg <= win_end ? '0 : acc_sum;
			end
		end

		// Window total held while it is scaled
		always_ff @(posedge i_sys_clk or posedge i_reset) begin
			if (i_reset) begin
				acc_hold_reg <= '0;
			end else if (win_end) begin
				acc_hold_reg <= acc_sum;
			end
		end

		// Scaled angle step, 32-bit pair in one register
		always_ff @(posedge i_sys_clk or posedge i_reset) begin
			if (i_reset) begin
				angle_reg <= 32'h0000_0000;
			end else if (scaling) begin
				angle_reg <= angle_sat;
			end
		end

		// Published step, moves in the same edge as rate and accel
		always_ff @(posedge i_sys_clk or posedge i_reset) begin
			if (i_reset) begin
				angle_pub_reg <= 32'h0000_0000;
			end else if (publishing) begin
				angle_pub_reg <= angle_reg;
			end
		end

		assign angle_w[a] = angle_pub_reg;
	end

	// Sequencer: latch window, scale, then publish together
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (win_end) begin
					state_next = ST_SCALE;
				end
			end
			ST_SCALE: begin
				state_next = ST_PUBLISH;
			end
			ST_PUBLISH: begin
				state_next = ST_RUN;
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// State decode shared by the datapath
	assign scaling = (state_reg == ST_SCALE);
	assign publishing = (state_reg == ST_PUBLISH);

	// Scale of the window just closed, held for the multiply
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			scale_reg <= INT_SCALE_Q32;
		end else if (win_end) begin
			scale_reg <= scale_sel;
		end
	end

	// Z rate taken at the window-end sample
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			z_rate_hold_reg <= 32'h0000_0000;
		end else if (win_end) begin
			z_rate_hold_reg <= i_rate.z;
		end
	end

	// Published outputs: whole pairs move in one edge
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			z_rate_reg <= 32'h0000_0000;
			accel_reg <= '0;
		end else if (publishing) begin
			z_rate_reg <= z_rate_hold_reg;
			accel_reg <= i_accel;
		end
	end

	// Update strobe, one cycle once the pairs have moved
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			update_reg <= 1'b0;
		end else begin
			update_reg <= publishing;
		end
	end

	// Page select register, writable on every page at address 0x00
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			page_reg <= PAGE_SELECT_RESET;
		end else if (page_wr) begin
			page_reg <= i_reg_req.wdata;
		end
	end

	// Read decode, output words only on page zero
	assign page_hit = is_page_addr(i_reg_req.addr);
	assign page_wr = i_reg_req.wr && page_hit;
	assign on_outputs = (page_reg == PAGE_OUTPUTS);

	always_comb begin
		rd_word = READ_ZERO;
		rd_hit = 1'b1;
		case ({i_reg_req.addr[6:1], 1'b0})
			ADDR_PAGE_SELECT: rd_word = page_reg;
			ADDR_Z_RATE_LOW: rd_word = pair_word(z_rate_reg, 1'b0);
			ADDR_Z_RATE_HIGH: rd_word = pair_word(z_rate_reg, 1'b1);
			ADDR_X_ANGLE_LOW: rd_word = pair_word(angle_w[0], 1'b0);
			ADDR_X_ANGLE_HIGH: rd_word = pair_word(angle_w[0], 1'b1);
			ADDR_Y_ANGLE_LOW: rd_word = pair_word(angle_w[1], 1'b0);
			ADDR_Y_ANGLE_HIGH: rd_word = pair_word(angle_w[1], 1'b1);
			ADDR_Z_ANGLE_LOW: rd_word = pair_word(angle_w[2], 1'b0);
			ADDR_Z_ANGLE_HIGH: rd_word = pair_word(angle_w[2], 1'b1);
			default: rd_hit = 1'b0;
		endcase
	end

	// Read word: page select on any page, outputs on page zero
	assign rd_sel = page_hit ? page_reg :
		(on_outputs && rd_hit) ? rd_word : READ_ZERO;

	// Read data register; writes to output words are ignored
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			rdata_reg <= READ_ZERO;
		end else if (i_reg_req.rd) begin
			rdata_reg <= rd_sel;
		end
	end

	// Read strobe, one cycle after the request
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= i_reg_req.rd;
		end
	end

	// Port drive
	assign o_reg_rdata = rdata_reg;
	assign o_reg_rvalid = rvalid_reg;
	assign o_register_page_select = page_reg;
	assign o_accel_words = accel_reg;
	assign o_sample_tick = sample_tick;
	assign o_data_update = update_reg;

endmodule

// ---- sim/iad_angle_regs_chk.sv ----
module iad_angle_regs_chk (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ext_clk_sel,
	input wire logic [15:0] i_decimation_setting,
	input wire iad_pkg::iad_reg_req_t i_reg_req,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	input wire logic [15:0] o_register_page_select,
	input wire logic o_sample_tick,
	input wire logic o_data_update
);
	timeunit 1ns;
	timeprecision 1ns;
	import iad_pkg::*;
	logic [11:0] gap_reg;
	logic seen_reg;
	// Page write and off-page read decode
	wire pg_wr = i_reg_req.wr && i_reg_req.addr[6:1] == 6'h00;
	wire off_rd = i_reg_req.rd && i_reg_req.addr[6:1] != 6'h00
		&& o_register_page_select != PAGE_OUTPUTS;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// Cycles since the last sample tick from either source
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			gap_reg <= 12'h000;
			seen_reg <= 1'b0;
		end else begin
			gap_reg <= o_sample_tick ? 12'h000 : gap_reg + 12'h001;
			seen_reg <= (seen_reg | o_sample_tick) & ~i_ext_clk_sel;
		end
	end
	rd_answer_a: assert property (i_reg_req.rd |=> o_reg_rvalid)
		else $error("read not answered");
	rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_req.rd))
		else $error("answer without read");
	page_load_a: assert property (pg_wr |=>
		o_register_page_select == $past(i_reg_req.wdata))
		else $error("page not loaded");
	page_hold_a: assert property (!pg_wr |=> $stable(o_register_page_select))
		else $error("page changed");
	off_page_a: assert property (off_rd |=> o_reg_rdata == READ_ZERO)
		else $error("off page read not zero");
	tick_gap_a: assert property (o_sample_tick |=> !o_sample_tick [*3])
		else $error("ticks too close");
	int_period_a: assert property (o_sample_tick && seen_reg &&
		!i_ext_clk_sel |-> gap_reg == INT_TICK_LAST)
		else $error("internal tick period wrong");
	update_cause_a: assert property (o_data_update |-> $past(o_sample_tick, 3))
		else $error("update without tick");
	single_window_a: assert property (o_sample_tick &&
		i_decimation_setting == 16'h0000 |-> ##3 o_data_update)
		else $error("setting zero window missed");
	update_pulse_a: assert property (o_data_update |=> !o_data_update)
		else $error("update pulse too long");
	cover property (o_data_update);
	cover property (pg_wr);
	cover property (off_rd);
	cover property (o_sample_tick && i_ext_clk_sel);
endmodule

// ---- sim/iad_host_model.sv ----
module iad_host_model (
	input wire logic i_sys_clk,
	input wire logic [15:0] i_reg_rdata,
	input wire logic i_reg_rvalid,
	output iad_pkg::iad_reg_req_t o_reg_req
);
	timeunit 1ns;
	timeprecision 1ns;
	import iad_pkg::*;
	initial o_reg_req = '0;
	// One access held over its taking edge; idle fields inverted
	task automatic access(input logic wr, input logic [6:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(negedge i_sys_clk);
		o_reg_req = '{rd: !wr, wr: wr, addr: a, wdata: d};
		@(negedge i_sys_clk);
		o_reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
		q = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
	endtask
	// Whole pair, low word then high word
	task automatic rd32(input logic [6:0] a, output logic [31:0] v);
		logic [15:0] lo, hi;
		access(1'b0, a, 16'h0000, lo);
		access(1'b0, a + 7'h02, 16'h0000, hi);
		v = {hi, lo};
	endtask
	// Page selection write
	task automatic set_page(input logic [15:0] p);
		logic [15:0] q;
		access(1'b1, ADDR_PAGE_SELECT, p, q);
	endtask
endmodule

// ---- sim/test_inertial_output_and_delta_angle_regs.sv ----
module test_inertial_output_and_delta_angle_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import iad_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_ext_clk_sel = 1'b0;
	logic i_ext_sample_clk = 1'b0;
	logic [31:0] i_ext_scale_q32 = 32'h0;
	logic [15:0] i_decimation_setting = 16'h0;
	iad_axes_t i_rate = '0;
	iad_axes_t i_accel = {32'h1234_5678, 32'h8000_0001, 32'hffff_fffe};
	iad_reg_req_t i_reg_req;
	logic [15:0] o_reg_rdata, o_register_page_select;
	logic o_reg_rvalid, o_sample_tick, o_data_update;
	iad_axes_t o_accel_words;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int k;
	logic [31:0] a;
	logic [15:0] q;
	// Clocks; external sample clock runs only while selected
	always #50 i_sys_clk = ~i_sys_clk;
	always #1000 i_ext_sample_clk = i_ext_clk_sel & ~i_ext_sample_clk;
	iad_angle_regs i_dut (.i_sys_clk, .i_reset, .i_ext_clk_sel,
		.i_ext_sample_clk, .i_ext_scale_q32, .i_decimation_setting,
		.i_rate, .i_accel, .i_reg_req, .o_reg_rdata, .o_reg_rvalid,
		.o_register_page_select, .o_accel_words, .o_sample_tick,
		.o_data_update);
	iad_host_model u_host (.i_sys_clk, .i_reg_rdata(o_reg_rdata),
		.i_reg_rvalid(o_reg_rvalid), .o_reg_req(i_reg_req));
	task automatic chk(input string n, input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Cycle ceiling for a hang
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 45000) begin
			bad_count++;
			stop_test();
		end
	end
	// Cycles up to the next output update
	task automatic wait_upd(output int n);
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while (o_data_update !== 1'b1 && n < 8000);
		chk("update seen", 32'h1, {31'h0, o_data_update});
	endtask
	// Expected angle step: m rate terms, scaled, floored
	function automatic logic [31:0] ang(input logic [31:0] r, input int m,
		input logic [31:0] s);
		return 32'((longint'(signed'(r)) * m * longint'(s)) >>> 32);
	endfunction
	// Both rate extremes, every pair, accel words
	task automatic t_rates;
		logic [31:0] tab [2] = '{32'h4e20_0000, 32'hb1e0_0000};
		logic [31:0] x, y, z;
		foreach (tab[i]) begin
			wait_upd(k);
			i_rate = '{tab[i], -tab[i], tab[i]};
			wait_upd(k);
			wait_upd(k);
			u_host.rd32(ADDR_X_ANGLE_LOW, x);
			u_host.rd32(ADDR_Y_ANGLE_LOW, y);
			u_host.rd32(ADDR_Z_ANGLE_LOW, z);
			u_host.rd32(ADDR_Z_RATE_LOW, a);
			chk("x angle", ang(tab[i], 2, INT_SCALE_Q32), x);
			chk("y angle", ang(-tab[i], 2, INT_SCALE_Q32), y);
			chk("z angle", ang(tab[i], 2, INT_SCALE_Q32), z);
			chk("z rate", tab[i], a);
			chk("accel x", i_accel.x, o_accel_words.x);
			chk("accel y", i_accel.y, o_accel_words.y);
			chk("accel z", i_accel.z, o_accel_words.z);
		end
	endtask
	// Other page hides outputs; read-only words ignore writes
	task automatic t_page;
		u_host.set_page(16'h0002);
		chk("page", 16'h0002, o_register_page_select);
		u_host.rd32(ADDR_X_ANGLE_LOW, a);
		chk("off page", 32'h0, a);
		u_host.access(1'b0, ADDR_PAGE_SELECT, 16'h0, q);
		chk("page read", 16'h0002, q);
		u_host.set_page(PAGE_OUTPUTS);
		u_host.access(1'b0, 7'h20, 16'h0, q);
		chk("unmapped", 32'h0, q);
		u_host.access(1'b1, ADDR_Z_RATE_HIGH, 16'h1234, q);
		u_host.rd32(ADDR_Z_RATE_LOW, a);
		chk("z rate kept", 32'hb1e0_0000, a);
	endtask
	// Window of setting plus one samples
	task automatic t_dec;
		i_decimation_setting = 16'h0002;
		wait_upd(k);
		wait_upd(k);
		chk("window", 3 * INT_SAMPLE_CYCLES, k);
		u_host.rd32(ADDR_X_ANGLE_LOW, a);
		chk("dec angle", ang(32'hb1e0_0000, 6, INT_SCALE_Q32), a);
		i_decimation_setting = 16'h0000;
	endtask
	// External sample clock, decimation kept at zero
	task automatic t_ext;
		i_ext_scale_q32 = 32'h0002_0000;
		i_ext_clk_sel = 1'b1;
		wait_upd(k);
		wait_upd(k);
		wait_upd(k);
		chk("ext period", 20, k);
		u_host.rd32(ADDR_X_ANGLE_LOW, a);
		chk("ext angle", ang(32'hb1e0_0000, 2, 32'h0002_0000), a);
		i_ext_clk_sel = 1'b0;
	endtask
	initial begin
		repeat (2) @(negedge i_sys_clk);
		i_reset = 1'b0;
		chk("page reset", PAGE_SELECT_RESET, o_register_page_select);
		t_rates();
		t_page();
		t_dec();
		t_ext();
		stop_test();
	end
endmodule
bind iad_angle_regs iad_angle_regs_chk u_chk (.i_sys_clk, .i_reset,
	.i_ext_clk_sel, .i_decimation_setting, .i_reg_req, .o_reg_rdata,
	.o_reg_rvalid, .o_register_page_select, .o_sample_tick,
	.o_data_update);
